// ---- rtl/clk_out_gate.sv ----
// Registered enable for each clock output driver.
// Assumes all disable terms arrive on ref_clk from the register bank.
`timescale 1ns/1ns
module clk_out_gate
    import pin_cfg_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    out_gate_if.gate  gif
);

    logic [NUM_OUT-1:0] drv_en_r;

    // Drivers start disabled so no glitchy clock leaves the part before configuration settles.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drv_en_r <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                drv_en_r[i] <= ~(gif.pin_gate | gif.lock_gate | gif.out_dis[i]);
            end
        end
    end

    assign gif.drv_en = drv_en_r;

endmodule : clk_out_gate

// ---- rtl/out_gate_if.sv ----
// Interface carrying the disable terms for the clock output drivers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface out_gate_if;
    import pin_cfg_pkg::*;

    logic               pin_gate;
    logic               lock_gate;
    logic [NUM_OUT-1:0] out_dis;
    logic [NUM_OUT-1:0] drv_en;

    modport ctrl (output pin_gate, output lock_gate, output out_dis, input drv_en);
    modport gate (input pin_gate, input lock_gate, input out_dis, output drv_en);

endinterface : out_gate_if

// ---- rtl/pin_cfg_pkg.sv ----
// Constants shared by the reference divider and pin configuration register bank.
// Assumes register selects, bit positions and reset values are used by name only.
package pin_cfg_pkg;

    // Register selects on the serial-port register access port.
    localparam logic [1:0]  SEL_PREDIV        = 2'h0;
    localparam logic [1:0]  SEL_OE_CFG        = 2'h1;
    localparam logic [1:0]  SEL_IO_CFG        = 2'h2;

    // Reference predivider control fields.
    localparam int          PREDIV_SETB_BIT   = 22;
    localparam int          PREDIV_ENB_BIT    = 21;
    localparam logic [31:0] PREDIV_RESET      = 32'h0040_0000;
    localparam logic [31:0] PREDIV_WMASK      = 32'h0060_0000;

    // Output-enable pin configuration fields.
    localparam int          ENABLE_PIN_PULLDOWN_BIT         = 5;
    localparam int          ENABLE_PIN_PULLUP_BIT         = 4;
    localparam int          OE_POL_BIT        = 3;
    localparam int          OE_SEL_BIT        = 0;
    localparam logic [7:0]  OE_CFG_RESET      = 8'h10;
    localparam logic [7:0]  OE_CFG_WMASK      = 8'h39;

    // Miscellaneous pad configuration fields.
    localparam int          IO_STARTUP_MSB    = 7;
    localparam int          IO_STARTUP_LSB    = 6;
    localparam int          IO_PP_MSB         = 5;
    localparam int          IO_PP_LSB         = 4;
    localparam int          IO_OD_MSB         = 3;
    localparam int          IO_OD_LSB         = 2;
    localparam int          IO_SERIAL_DATA_PULLUP_BIT     = 1;
    localparam int          IO_SERIAL_CLOCK_PULLUP_BIT     = 0;
    localparam logic [7:0]  IO_CFG_RESET      = 8'h2f;
    localparam logic [7:0]  IO_CFG_WMASK      = 8'hff;

    // Startup output gating codes.
    localparam logic [1:0]  STARTUP_WAIT_LOCK = 2'h0;
    localparam logic [1:0]  STARTUP_NO_GATE   = 2'h2;

    // Number of clock output drivers.
    localparam int          NUM_OUT           = 4;

endpackage : pin_cfg_pkg

// ---- rtl/ref_div_and_pin_config_regs.sv ----
// Reference divider control and pin configuration register bank of the clock synthesizer.
// Assumes register accesses come from the serial-port logic on ref_clk; pins and lock are asynchronous.
`timescale 1ns/1ns
module ref_div_and_pin_config_regs
    import pin_cfg_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic               cfg_wr,
    input  wire logic               cfg_rd,
    input  wire logic [1:0]         cfg_sel,
    input  wire logic [31:0]        cfg_wdata,
    output logic      [31:0]        cfg_rdata,
    output logic                    cfg_rvalid,
    input  wire logic               spi_mode,
    input  wire logic               startup_active,
    input  wire logic [NUM_OUT-1:0] out_dis,
    input  wire logic               apll_lock,
    input  wire logic               enable_or_chip_select_pin,
    output logic                    div_hold_set,
    output logic                    div_run,
    output logic                    enable_pin_pulldown,
    output logic                    enable_pin_pullup,
    output logic [1:0]              push_pull_strength,
    output logic [1:0]              open_drain_strength,
    output logic                    serial_data_pullup,
    output logic                    serial_clock_pullup,
    output logic [NUM_OUT-1:0]      clk_out_en
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [31:0] prediv_r;
    logic [7:0]  oe_cfg_r;
    logic [7:0]  io_cfg_r;
    logic [31:0] rdata_r;
    logic        rvalid_r;
    logic        div_hold_set_r;
    logic        div_run_r;

    // Reserved bits are masked on write so they always read back as zero.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prediv_r <= PREDIV_RESET;
            oe_cfg_r <= OE_CFG_RESET;
            io_cfg_r <= IO_CFG_RESET;
        end else if (cfg_wr) begin
            unique case (cfg_sel)
                SEL_PREDIV: prediv_r <= cfg_wdata & PREDIV_WMASK;
                SEL_OE_CFG: oe_cfg_r <= cfg_wdata[7:0] & OE_CFG_WMASK;
                SEL_IO_CFG: io_cfg_r <= cfg_wdata[7:0] & IO_CFG_WMASK;
                default: ;
            endcase
        end
    end

    // An unmapped select reads as zero.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                unique case (cfg_sel)
                    SEL_PREDIV: rdata_r <= prediv_r;
                    SEL_OE_CFG: rdata_r <= {24'h00_0000, oe_cfg_r};
                    SEL_IO_CFG: rdata_r <= {24'h00_0000, io_cfg_r};
                    default:    rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign cfg_rdata  = rdata_r;
    assign cfg_rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference divider controls, registered so the outputs come straight from flops.

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_hold_set_r <= 1'b0;
            div_run_r      <= 1'b0;
        end else begin
            div_hold_set_r <= ~prediv_r[PREDIV_SETB_BIT];
            div_run_r      <= ~prediv_r[PREDIV_ENB_BIT];
        end
    end

    assign div_hold_set = div_hold_set_r;
    assign div_run      = div_run_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Pad settings are taken directly from the configuration flops.

    assign enable_pin_pulldown = oe_cfg_r[ENABLE_PIN_PULLDOWN_BIT];
    assign enable_pin_pullup   = oe_cfg_r[ENABLE_PIN_PULLUP_BIT];
    assign push_pull_strength  = io_cfg_r[IO_PP_MSB:IO_PP_LSB];
    assign open_drain_strength = io_cfg_r[IO_OD_MSB:IO_OD_LSB];
    assign serial_data_pullup  = io_cfg_r[IO_SERIAL_DATA_PULLUP_BIT];
    assign serial_clock_pullup = io_cfg_r[IO_SERIAL_CLOCK_PULLUP_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for the enable pin and the analog lock indication.

    logic pin_s1_r;
    logic pin_s2_r;
    logic lock_s1_r;
    logic lock_s2_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else begin
            pin_s1_r  <= enable_or_chip_select_pin;
            pin_s2_r  <= pin_s1_r;
            lock_s1_r <= apll_lock;
            lock_s2_r <= lock_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output driver gating.

    logic       pin_active;
    logic       pin_gate;
    logic       lock_gate;
    logic [1:0] startup_code;

    assign startup_code = io_cfg_r[IO_STARTUP_MSB:IO_STARTUP_LSB];
    // Polarity flips the pin sense; the select and polarity only matter outside SPI mode.
    assign pin_active = pin_s2_r ^ oe_cfg_r[OE_POL_BIT];
    assign pin_gate   = ~spi_mode & ~oe_cfg_r[OE_SEL_BIT] & ~pin_active;
    // Reserved codes behave like the no-gating code so a stray write cannot stall the outputs.
    assign lock_gate  = startup_active & ~lock_s2_r & (startup_code == STARTUP_WAIT_LOCK);

    out_gate_if gif ();

    assign gif.pin_gate  = pin_gate;
    assign gif.lock_gate = lock_gate;
    assign gif.out_dis   = out_dis;

    clk_out_gate u_gate (
        .ref_clk (ref_clk),
        .srst    (srst),
        .gif     (gif)
    );

    assign clk_out_en = gif.drv_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_wr_oe;
        cfg_wr && cfg_sel == SEL_OE_CFG;
    endsequence

    sequence s_wr_io;
        cfg_wr && cfg_sel == SEL_IO_CFG;
    endsequence

    sequence s_pin_disables;
        !spi_mode && !oe_cfg_r[OE_SEL_BIT] && (pin_s2_r == oe_cfg_r[OE_POL_BIT]);
    endsequence

    a_div_hold_set: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_wr && cfg_sel == SEL_PREDIV && !cfg_wdata[PREDIV_SETB_BIT] |=> ##1 div_hold_set)
        else $error("divider not held in set after clearing set bit");

    a_div_run_enb: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_wr && cfg_sel == SEL_PREDIV |=> ##1 div_run == !$past(cfg_wdata[PREDIV_ENB_BIT], 2))
        else $error("divider run does not follow its active-low enable");

    a_enable_pin_pulls: assert property (@(posedge ref_clk) disable iff (srst)
        s_wr_oe |=> enable_pin_pulldown == $past(cfg_wdata[ENABLE_PIN_PULLDOWN_BIT])
                    && enable_pin_pullup == $past(cfg_wdata[ENABLE_PIN_PULLUP_BIT]))
        else $error("enable pin pulls do not follow write");

    a_pin_gates_outputs: assert property (@(posedge ref_clk) disable iff (srst)
        s_pin_disables |=> clk_out_en == '0)
        else $error("inactive enable pin did not disable the outputs");

    a_spi_ignores_pin: assert property (@(posedge ref_clk) disable iff (srst)
        spi_mode && !lock_gate && out_dis == '0 |=> &clk_out_en)
        else $error("enable pin gated outputs in SPI mode");

    a_sel_ignores_pin: assert property (@(posedge ref_clk) disable iff (srst)
        oe_cfg_r[OE_SEL_BIT] && !lock_gate && out_dis == '0 |=> &clk_out_en)
        else $error("enable pin gated outputs with select set");

    a_startup_lock_gate: assert property (@(posedge ref_clk) disable iff (srst)
        startup_active && !lock_s2_r && startup_code == STARTUP_WAIT_LOCK |=> clk_out_en == '0)
        else $error("outputs enabled before lock during startup");

    a_startup_no_gate: assert property (@(posedge ref_clk) disable iff (srst)
        startup_code == STARTUP_NO_GATE && !pin_gate && out_dis == '0 |=> &clk_out_en)
        else $error("outputs gated on lock with no-gating code");

    a_drive_strengths: assert property (@(posedge ref_clk) disable iff (srst)
        s_wr_io |=> push_pull_strength == $past(cfg_wdata[IO_PP_MSB:IO_PP_LSB])
                    && open_drain_strength == $past(cfg_wdata[IO_OD_MSB:IO_OD_LSB]))
        else $error("drive strengths do not follow write");

    a_serial_pullups: assert property (@(posedge ref_clk) disable iff (srst)
        s_wr_io |=> serial_data_pullup == $past(cfg_wdata[IO_SERIAL_DATA_PULLUP_BIT])
                    && serial_clock_pullup == $past(cfg_wdata[IO_SERIAL_CLOCK_PULLUP_BIT]))
        else $error("serial pull-ups do not follow write");

    a_per_output_dis: assert property (@(posedge ref_clk) disable iff (srst)
        out_dis != '0 |=> (clk_out_en & $past(out_dis)) == '0)
        else $error("disabled output driver was enabled");

endmodule : ref_div_and_pin_config_regs

// ---- tb/ref_div_and_pin_config_regs_test.sv ----
// Self-checking testbench for the reference divider and pin configuration register bank.
// Assumes the bench drives every input itself at the falling edge; there is no far-side model.
`timescale 1ns/1ns
module ref_div_and_pin_config_regs_test;
    import pin_cfg_pkg::*;

    logic               ref_clk;
    logic               srst;
    logic               cfg_wr;
    logic               cfg_rd;
    logic [1:0]         cfg_sel;
    logic [31:0]        cfg_wdata;
    logic [31:0]        cfg_rdata;
    logic               cfg_rvalid;
    logic               spi_mode;
    logic               startup_active;
    logic [NUM_OUT-1:0] out_dis;
    logic               apll_lock;
    logic               enable_or_chip_select_pin;
    logic               div_hold_set;
    logic               div_run;
    logic               enable_pin_pulldown;
    logic               enable_pin_pullup;
    logic [1:0]         push_pull_strength;
    logic [1:0]         open_drain_strength;
    logic               serial_data_pullup;
    logic               serial_clock_pullup;
    logic [NUM_OUT-1:0] clk_out_en;
    int                 errors;
    int                 num_checks;

    ref_div_and_pin_config_regs ref_div_and_pin_config_regs_inst (
        .ref_clk(ref_clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_sel(cfg_sel),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .spi_mode(spi_mode),
        .startup_active(startup_active), .out_dis(out_dis), .apll_lock(apll_lock),
        .enable_or_chip_select_pin(enable_or_chip_select_pin), .div_hold_set(div_hold_set),
        .div_run(div_run), .enable_pin_pulldown(enable_pin_pulldown), .enable_pin_pullup(enable_pin_pullup),
        .push_pull_strength(push_pull_strength), .open_drain_strength(open_drain_strength),
        .serial_data_pullup(serial_data_pullup), .serial_clock_pullup(serial_clock_pullup),
        .clk_out_en(clk_out_en)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] sel, input logic [31:0] data);
        @(negedge ref_clk);
        cfg_sel   = sel;
        cfg_wdata = data;
        cfg_wr    = 1'b1;
        @(negedge ref_clk);
        cfg_wr    = 1'b0;
    endtask : wr

    // The read valid stands for a single cycle, so the answer is sampled in that cycle only.
    task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
        @(negedge ref_clk);
        cfg_sel = sel;
        cfg_rd  = 1'b1;
        @(negedge ref_clk);
        cfg_rd  = 1'b0;
        chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
        chk("cfg_rdata", exp, cfg_rdata);
    endtask : rd

    // The pin and lock pass two synchroniser flops before the enable flop, so allow four edges.
    task automatic en_chk(input logic pin, input logic [NUM_OUT-1:0] exp);
        enable_or_chip_select_pin = pin;
        repeat (4) @(negedge ref_clk);
        chk("clk_out_en", {28'h0, exp}, {28'h0, clk_out_en});
    endtask : en_chk

    task automatic pads_chk(input logic [7:0] exp);
        chk("pads", {24'h0, exp}, {24'h0, 2'h0, enable_pin_pulldown, enable_pin_pullup,
            push_pull_strength, open_drain_strength});
    endtask : pads_chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    initial begin
        errors = 0; num_checks = 0; srst = 1'b1; cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_sel = 2'h0;
        cfg_wdata = 32'h0; spi_mode = 1'b0; startup_active = 1'b0; out_dis = '0; apll_lock = 1'b0;
        enable_or_chip_select_pin = 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        pads_chk(8'h1b);
        chk("pullups", 32'h3, {30'h0, serial_data_pullup, serial_clock_pullup});
        chk("div", 32'h1, {30'h0, div_hold_set, div_run});
        rd(SEL_PREDIV, 32'h0040_0000);
        rd(SEL_OE_CFG, 32'h10);
        rd(SEL_IO_CFG, 32'h2f);
        rd(2'h3, 32'h0);
        // Reserved bits are written as ones to show that only the documented fields stick.
        wr(SEL_PREDIV, 32'hffff_ffff);
        repeat (2) @(negedge ref_clk);
        chk("div", 32'h0, {30'h0, div_hold_set, div_run});
        rd(SEL_PREDIV, 32'h0060_0000);
        wr(SEL_PREDIV, 32'h0);
        repeat (2) @(negedge ref_clk);
        chk("div", 32'h3, {30'h0, div_hold_set, div_run});
        wr(SEL_OE_CFG, 32'hff);
        pads_chk(8'h3b);
        wr(2'h3, 32'h0);
        rd(SEL_OE_CFG, 32'h39);
        for (int c = 0; c < 4; c++) begin
            wr(SEL_IO_CFG, {26'h0, c[1:0], ~c[1:0], 2'h0});
            pads_chk({4'h3, c[1:0], ~c[1:0]});
        end
        wr(SEL_IO_CFG, 32'h0);
        chk("pullups", 32'h0, {30'h0, serial_data_pullup, serial_clock_pullup});
        wr(SEL_OE_CFG, 32'h0);
        en_chk(1'b1, 4'hf);
        en_chk(1'b0, 4'h0);
        spi_mode = 1'b1;
        en_chk(1'b0, 4'hf);
        spi_mode = 1'b0;
        wr(SEL_OE_CFG, 32'h08);
        en_chk(1'b0, 4'hf);
        en_chk(1'b1, 4'h0);
        wr(SEL_OE_CFG, 32'h09);
        en_chk(1'b1, 4'hf);
        startup_active = 1'b1;
        en_chk(1'b1, 4'h0);
        wr(SEL_IO_CFG, 32'h80);
        en_chk(1'b1, 4'hf);
        wr(SEL_IO_CFG, 32'h00);
        apll_lock = 1'b1;
        en_chk(1'b1, 4'hf);
        out_dis = 4'h5;
        en_chk(1'b1, 4'ha);
        print_verdict();
    end

endmodule : ref_div_and_pin_config_regs_test
